// ===== common/mac_pkg.sv
// Constants shared by the multiply-accumulate engine and its rounder.
// Assumes a byte-wide special function register bus on the system clock.
`default_nettype none
package mac_pkg;
  localparam int ACC_W = 40;
  localparam int OP_W  = 16;
  localparam int RND_W = 16;

  // Register addresses on the special function register bus
  localparam logic [7:0] ADDR_OPERAND_A_HIGH      = 8'hA5;
  localparam logic [7:0] ADDR_OPERAND_A_LOW       = 8'hA4;
  localparam logic [7:0] ADDR_OPERAND_B_HIGH      = 8'hA6;
  localparam logic [7:0] ADDR_OPERAND_B_LOW       = 8'hA7;
  localparam logic [7:0] ADDR_MAC_STATUS          = 8'hCF;
  localparam logic [7:0] ADDR_ROUNDED_RESULT_LOW  = 8'hCD;
  localparam logic [7:0] ADDR_ROUNDED_RESULT_HIGH = 8'hCE;
  localparam logic [7:0] ADDR_ACCUMULATOR_BYTE0   = 8'hD2;
  localparam logic [7:0] ADDR_ACCUMULATOR_BYTE1   = 8'hD3;
  localparam logic [7:0] ADDR_ACCUMULATOR_BYTE2   = 8'hD4;
  localparam logic [7:0] ADDR_ACCUMULATOR_BYTE3   = 8'hD5;
  localparam logic [7:0] ADDR_ACCUMULATOR_TOP     = 8'hD6;
  localparam logic [7:0] ADDR_MAC_CONFIG          = 8'hD7;

  // Configuration fields
  localparam int CFG_SHIFT_REQUEST     = 5;
  localparam int CFG_SHIFT_DIRECTION   = 4;
  localparam int CFG_CLEAR_ACCUMULATOR = 3;
  localparam int CFG_SATURATE_ENABLE   = 2;
  localparam int CFG_FRACTIONAL_SELECT = 1;
  localparam int CFG_MULTIPLY_ONLY     = 0;
  localparam logic [7:0] CFG_WRITE_MASK = 8'h3F;
  localparam logic [7:0] CFG_RESET      = 8'h00;

  // Status fields
  localparam int STA_HARD_OVERFLOW = 3;
  localparam int STA_ZERO          = 2;
  localparam int STA_SOFT_OVERFLOW = 1;
  localparam int STA_NEGATIVE      = 0;
  localparam logic [7:0] STA_WRITE_MASK = 8'h0F;
  localparam logic [7:0] STA_RESET      = 8'h04;

  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Arithmetic thresholds
  localparam logic [7:0]  TOP_POS_LIMIT = 8'h7F;
  localparam logic [7:0]  TOP_NEG_LIMIT = 8'h80;
  localparam logic [15:0] ROUND_HALF    = 16'h8000;
  localparam logic [15:0] SAT_POSITIVE  = 16'h7FFF;
  localparam logic [15:0] SAT_NEGATIVE  = 16'h8000;

  // Bits 39..31 disagree: the value no longer fits in 32 signed bits
  function automatic logic soft_overflow(input logic [ACC_W-1:0] acc);
    soft_overflow = !((&acc[ACC_W-1:31]) || !(|acc[ACC_W-1:31]));
  endfunction
endpackage
`default_nettype wire

// ===== design/mac_rounder.sv
// Rounding and saturation of accumulator bits 31..16.
// Purely combinational; the engine registers the result when it is due.
`default_nettype none
module mac_rounder (
  input  wire logic [mac_pkg::ACC_W-1:0] acc,
  input  wire logic                      saturate,
  output logic      [mac_pkg::RND_W-1:0] result
);
  import mac_pkg::*;

  logic       round_up;
  logic [RND_W-1:0] upper;
  logic       carry_over;

  always_comb begin
    upper = acc[31:16];
    // Ties go to the even neighbour so the bias averages out
    round_up = (acc[15:0] > ROUND_HALF) || ((acc[15:0] == ROUND_HALF) && acc[16]);
    carry_over = round_up && (upper == SAT_POSITIVE);
    result = upper + {{(RND_W-1){1'b0}}, round_up};
    if (saturate && (soft_overflow(acc) || carry_over)) begin
      result = acc[ACC_W-1] ? SAT_NEGATIVE : SAT_POSITIVE;
    end
  end
endmodule
`default_nettype wire

// ===== design/multiply_accumulate_engine.sv
// Multiply-accumulate engine: 16x16 signed multiply, 40-bit accumulator,
// one-bit shift, rounding register and status flags behind byte registers.
// Assumes the core drives the register bus from logic on the same clock.
//
// How it works
// - Shift request moves the whole 40-bit accumulator one bit, then self-clears.
// - Shift direction bit 4: zero shifts left, one shifts right.
// - Clear bit 3 zeroes accumulator and resets status in the same next cycle, then self-clears.
// - Saturate bit 2 lets soft overflow saturate the rounded result only.
// - Format bit 1 selects integer or signed fractional operands.
// - Mode bit 0 selects accumulate or product overwriting the accumulator.
// - Unused config and status bits read zero and ignore writes.
// - Hard overflow sets on top byte crossing 7F/80; cleared by software or clear.
// - Zero flag follows whether the operation result is zero.
// - Soft overflow follows overflow into bit 31 on each operation.
// - Negative flag follows the sign of the accumulator result.
// - Top byte register holds accumulator bits 39..32.
// - Four byte registers hold accumulator bits 31..0, high to low.
// - Each operand splits into high byte 15..8 and low byte.
// - Writing operand B low byte launches an operation.
// - Three one-cycle stages: multiply, add with flags, round.
// - Rounding of bits 31..16 against half, ties round to even.
// - Saturated result reads 7FFF positive, 8000 negative.
// - Right shift keeps bit 39; shifts keep flags; multiply-only keeps hard overflow.
`default_nettype none
module multiply_accumulate_engine (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata
);
  import mac_pkg::*;

  logic [OP_W-1:0]  op_a_q;
  logic [OP_W-1:0]  op_a_d;
  logic [OP_W-1:0]  op_b_q;
  logic [OP_W-1:0]  op_b_d;
  logic [7:0]       cfg_q;
  logic [7:0]       cfg_d;
  logic [7:0]       sta_q;
  logic [7:0]       sta_d;
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_d;
  logic [ACC_W-1:0] prod_q;
  logic [ACC_W-1:0] prod_d;
  logic             start_q;
  logic             start_d;
  logic             add_q;
  logic             add_d;
  logic             only_q;
  logic             only_d;
  logic             round_q;
  logic             round_d;
  logic [RND_W-1:0] rnd_q;
  logic [RND_W-1:0] rnd_d;
  logic [7:0]       rdata_q;
  logic [7:0]       rdata_d;

  logic [ACC_W-1:0] sum;
  logic             ho_set;
  logic             wr_cfg;
  logic             wr_sta;
  logic [RND_W-1:0] rnd_next;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // Signed product, doubled in fractional mode to keep the point at bit 31
  function automatic logic [ACC_W-1:0] product(input logic [OP_W-1:0] a,
                                               input logic [OP_W-1:0] b,
                                               input logic            frac);
    logic signed [2*OP_W-1:0] p;
    logic signed [ACC_W-1:0]  wide;
    p = $signed(a) * $signed(b);
    wide = ACC_W'(p);
    product = frac ? {wide[ACC_W-2:0], 1'b0} : wide;
  endfunction

  function automatic logic [7:0] read_byte(input logic [7:0] addr);
    unique case (1'b1)
      hit(addr, ADDR_OPERAND_A_HIGH):      read_byte = op_a_q[15:8];
      hit(addr, ADDR_OPERAND_A_LOW):       read_byte = op_a_q[7:0];
      hit(addr, ADDR_OPERAND_B_HIGH):      read_byte = op_b_q[15:8];
      hit(addr, ADDR_OPERAND_B_LOW):       read_byte = op_b_q[7:0];
      hit(addr, ADDR_MAC_CONFIG):          read_byte = cfg_q & CFG_WRITE_MASK;
      hit(addr, ADDR_MAC_STATUS):          read_byte = sta_q & STA_WRITE_MASK;
      hit(addr, ADDR_ACCUMULATOR_TOP):     read_byte = acc_q[39:32];
      hit(addr, ADDR_ACCUMULATOR_BYTE3):   read_byte = acc_q[31:24];
      hit(addr, ADDR_ACCUMULATOR_BYTE2):   read_byte = acc_q[23:16];
      hit(addr, ADDR_ACCUMULATOR_BYTE1):   read_byte = acc_q[15:8];
      hit(addr, ADDR_ACCUMULATOR_BYTE0):   read_byte = acc_q[7:0];
      hit(addr, ADDR_ROUNDED_RESULT_HIGH): read_byte = rnd_q[15:8];
      hit(addr, ADDR_ROUNDED_RESULT_LOW):  read_byte = rnd_q[7:0];
      default:                             read_byte = 8'h00;
    endcase
  endfunction

  mac_rounder i_mac_rounder (
    .acc      (acc_q),
    .saturate (cfg_q[CFG_SATURATE_ENABLE]),
    .result   (rnd_next)
  );

  always_comb begin
    op_a_d  = op_a_q;
    op_b_d  = op_b_q;
    cfg_d   = cfg_q;
    sta_d   = sta_q;
    acc_d   = acc_q;
    prod_d  = prod_q;
    only_d  = only_q;
    rnd_d   = rnd_q;
    sum     = acc_q;
    ho_set  = 1'b0;
    wr_cfg  = sfr_wr && hit(sfr_addr, ADDR_MAC_CONFIG);
    wr_sta  = sfr_wr && hit(sfr_addr, ADDR_MAC_STATUS);

    // Operand bytes; the low byte of B also starts the pipeline
    if (sfr_wr && hit(sfr_addr, ADDR_OPERAND_A_HIGH)) begin
      op_a_d[15:8] = sfr_wdata;
    end
    if (sfr_wr && hit(sfr_addr, ADDR_OPERAND_A_LOW)) begin
      op_a_d[7:0] = sfr_wdata;
    end
    if (sfr_wr && hit(sfr_addr, ADDR_OPERAND_B_HIGH)) begin
      op_b_d[15:8] = sfr_wdata;
    end
    if (sfr_wr && hit(sfr_addr, ADDR_OPERAND_B_LOW)) begin
      op_b_d[7:0] = sfr_wdata;
    end
    start_d = sfr_wr && hit(sfr_addr, ADDR_OPERAND_B_LOW);

    // Stage one: multiply with the operands and mode now in place
    add_d = start_q;
    if (start_q) begin
      prod_d = product(op_a_q, op_b_q, cfg_q[CFG_FRACTIONAL_SELECT]);
      only_d = cfg_q[CFG_MULTIPLY_ONLY];
    end

    // Stage two: add, store and update flags
    if (add_q) begin
      sum = only_q ? prod_q : acc_q + prod_q;
      acc_d = sum;
      sta_d[STA_ZERO]          = (sum == '0);
      sta_d[STA_NEGATIVE]      = sum[ACC_W-1];
      sta_d[STA_SOFT_OVERFLOW] = soft_overflow(sum);
      // Multiply-only overwrites, so a top byte crossing means nothing there
      ho_set = !only_q &&
               (((acc_q[39:32] == TOP_POS_LIMIT) && (sum[39:32] == TOP_NEG_LIMIT)) ||
                ((acc_q[39:32] == TOP_NEG_LIMIT) && (sum[39:32] == TOP_POS_LIMIT)));
      if (ho_set) begin
        sta_d[STA_HARD_OVERFLOW] = 1'b1;
      end
    end

    // Shift leaves every flag as it is
    if (cfg_q[CFG_SHIFT_REQUEST]) begin
      if (cfg_q[CFG_SHIFT_DIRECTION]) begin
        acc_d = {acc_d[ACC_W-1], acc_d[ACC_W-1:1]};
      end else begin
        acc_d = {acc_d[ACC_W-2:0], 1'b0};
      end
      cfg_d[CFG_SHIFT_REQUEST] = 1'b0;
    end

    if (cfg_q[CFG_CLEAR_ACCUMULATOR]) begin
      acc_d = '0;
      sta_d = STA_RESET;
      ho_set = 1'b0;
      cfg_d[CFG_CLEAR_ACCUMULATOR] = 1'b0;
    end

    // Direct loads win over arithmetic in the same cycle
    if (sfr_wr && hit(sfr_addr, ADDR_ACCUMULATOR_TOP)) begin
      acc_d[39:32] = sfr_wdata;
    end
    if (sfr_wr && hit(sfr_addr, ADDR_ACCUMULATOR_BYTE3)) begin
      acc_d[31:24] = sfr_wdata;
    end
    if (sfr_wr && hit(sfr_addr, ADDR_ACCUMULATOR_BYTE2)) begin
      acc_d[23:16] = sfr_wdata;
    end
    if (sfr_wr && hit(sfr_addr, ADDR_ACCUMULATOR_BYTE1)) begin
      acc_d[15:8] = sfr_wdata;
    end
    if (sfr_wr && hit(sfr_addr, ADDR_ACCUMULATOR_BYTE0)) begin
      acc_d[7:0] = sfr_wdata;
    end

    if (wr_cfg) begin
      cfg_d = sfr_wdata & CFG_WRITE_MASK;
    end
    // A hard overflow arriving with a software clear survives it
    if (wr_sta) begin
      sta_d = (sfr_wdata & STA_WRITE_MASK) |
              (ho_set ? (8'h01 << STA_HARD_OVERFLOW) : 8'h00);
    end

    // Stage three, or the cycle after a shift or a low accumulator write
    round_d = add_q || cfg_q[CFG_SHIFT_REQUEST] ||
              (sfr_wr && hit(sfr_addr, ADDR_ACCUMULATOR_BYTE0));
    if (round_q) begin
      rnd_d = rnd_next;
    end

    rdata_d = sfr_rd ? read_byte(sfr_addr) : rdata_q;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      op_a_q  <= '0;
      op_b_q  <= '0;
      cfg_q   <= CFG_RESET;
      sta_q   <= STA_RESET;
      acc_q   <= '0;
      prod_q  <= '0;
      start_q <= 1'b0;
      add_q   <= 1'b0;
      only_q  <= 1'b0;
      round_q <= 1'b0;
      rnd_q   <= '0;
      rdata_q <= BYTE_RESET;
    end else begin
      op_a_q  <= op_a_d;
      op_b_q  <= op_b_d;
      cfg_q   <= cfg_d;
      sta_q   <= sta_d;
      acc_q   <= acc_d;
      prod_q  <= prod_d;
      start_q <= start_d;
      add_q   <= add_d;
      only_q  <= only_d;
      round_q <= round_d;
      rnd_q   <= rnd_d;
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata = rdata_q;
endmodule
`default_nettype wire

// ===== sim/sfr_core_model.sv
// Core model: masters the byte register bus on the system clock.
// Assumes the engine samples its strobes at the rising edge.
`default_nettype none
module sfr_core_model (
  input  wire logic       clk,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic            sfr_rd,
  output logic      [7:0] sfr_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end
  // One strobe cycle then a free one; released data flips so stale bytes never match
  task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= w;
    sfr_rd <= !w;
    sfr_addr <= a;
    sfr_wdata <= w ? d : ~sfr_wdata;
    @(posedge clk);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    sfr_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ===== sim/multiply_accumulate_engine_properties.sv
// Register bus checks of the engine, bound to its top module.
// Assumes read data follows one cycle after the taken read strobe.
`default_nettype none
module multiply_accumulate_engine_properties
  import mac_pkg::*;
(
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [7:0] sfr_addr,
  input wire logic       sfr_wr,
  input wire logic       sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic rc, rs, wc, ws, wb;
  assign rc = sfr_rd && sfr_addr == ADDR_MAC_CONFIG;
  assign rs = sfr_rd && sfr_addr == ADDR_MAC_STATUS;
  assign wc = sfr_wr && sfr_addr == ADDR_MAC_CONFIG;
  assign ws = sfr_wr && sfr_addr == ADDR_MAC_STATUS;
  assign wb = sfr_wr && sfr_addr inside {[ADDR_ACCUMULATOR_BYTE0:ADDR_ACCUMULATOR_TOP]};
  property p_cfg_hi; rc |=> sfr_rdata[7:6] == 2'h0; endproperty
  a_cfg_hi: assert property (p_cfg_hi) else $error("config top bits set");
  property p_sta_hi; rs |=> sfr_rdata[7:4] == 4'h0; endproperty
  a_sta_hi: assert property (p_sta_hi) else $error("status top bits set");
  property p_clr_self; wc && sfr_wdata[3] ##1 !sfr_wr ##1 rc |=> !sfr_rdata[3]; endproperty
  a_clr_self: assert property (p_clr_self) else $error("clear bit stuck");
  property p_shift_self; wc && sfr_wdata[5] ##1 !sfr_wr ##1 rc |=> !sfr_rdata[5]; endproperty
  a_shift_self: assert property (p_shift_self) else $error("shift bit stuck");
  property p_clr_status;
    !sfr_wr ##1 wc && sfr_wdata[3] ##1 !sfr_wr ##1 rs |=> sfr_rdata == STA_RESET;
  endproperty
  a_clr_status: assert property (p_clr_status) else $error("status not reset");
  property p_byte_load;
    !sfr_wr ##1 wb ##1 !sfr_wr ##1 sfr_rd && sfr_addr == $past(sfr_addr, 2)
      |=> sfr_rdata == $past(sfr_wdata, 3);
  endproperty
  a_byte_load: assert property (p_byte_load) else $error("byte load lost");
  property p_sta_write;
    !sfr_wr [*2] ##1 ws ##1 !sfr_wr ##1 rs
      |=> (sfr_rdata & STA_WRITE_MASK) == ($past(sfr_wdata, 3) & STA_WRITE_MASK);
  endproperty
  a_sta_write: assert property (p_sta_write) else $error("status write lost");
  property p_cfg_keep;
    wc ##1 !sfr_wr ##1 rc |=> (sfr_rdata & 8'h17) == ($past(sfr_wdata, 3) & 8'h17);
  endproperty
  a_cfg_keep: assert property (p_cfg_keep) else $error("config bits lost");
  property p_rdata_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  c_b2b: cover property (sfr_wr && sfr_addr == ADDR_OPERAND_B_LOW ##2 sfr_wr);
  c_shift: cover property (wc && sfr_wdata[5]);
  c_clear: cover property (wc && sfr_wdata[3]);
endmodule
bind multiply_accumulate_engine multiply_accumulate_engine_properties i_props (
  .clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata));
`default_nettype wire

// ===== sim/multiply_accumulate_engine_test.sv
// Testbench: core model writes registers, a monitor checks each read answer.
// Assumes the engine and core model share one 10 MHz clock.
`default_nettype none
module multiply_accumulate_engine_test;
  import mac_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic            clk = 1'b0;
  logic            resetn = 1'b0;
  wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  wire logic       sfr_wr, sfr_rd;
  logic            rd_pend = 1'b0;
  logic      [7:0] exp_q[$];
  logic     [39:0] acc_m = 40'h0;
  logic      [3:0] sta_m = 4'h4;
  logic     [15:0] rnd_m = 16'h0;
  logic            sat_m = 1'b0, frac_m = 1'b0, ms_m = 1'b0;
  int              err_count = 0, num_checks = 0, cycles = 0, seed = 32'h7A772329;
  logic      [7:0] tab[8] = '{ADDR_ACCUMULATOR_TOP, ADDR_ACCUMULATOR_BYTE3,
    ADDR_ACCUMULATOR_BYTE2, ADDR_ACCUMULATOR_BYTE1, ADDR_ACCUMULATOR_BYTE0,
    ADDR_MAC_STATUS, ADDR_ROUNDED_RESULT_HIGH, ADDR_ROUNDED_RESULT_LOW};
  sfr_core_model i_sfr_core_model (.clk(clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));
  multiply_accumulate_engine i_multiply_accumulate_engine (.clk(clk), .resetn(resetn),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata));
  initial forever #50 clk = ~clk;
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    num_checks++;
    if (seen !== want) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  always @(posedge clk) begin
    rd_pend <= sfr_rd;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  always @(negedge clk) begin
    if (rd_pend) check(sfr_rdata, exp_q.pop_front());
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_sfr_core_model.access(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_sfr_core_model.access(1'b0, a, 8'h00);
  endtask
  // Rounded copy moves only on stage three, a shift or a low byte load; a clear keeps it
  task automatic round_m;
    rnd_m = acc_m[31:16] + 16'(acc_m[15:0] > 16'h8000 ||
                               (acc_m[15:0] == 16'h8000 && acc_m[16]));
    if (sat_m && (!(&acc_m[39:31] || !(|acc_m[39:31])) || (acc_m[31:16] == 16'h7FFF
        && rnd_m == 16'h8000))) rnd_m = acc_m[39] ? 16'h8000 : 16'h7FFF;
  endtask
  task automatic cfg(input logic [7:0] v);
    wr(ADDR_MAC_CONFIG, v);
    {sat_m, frac_m, ms_m} = v[2:0];
    if (v[3]) {acc_m, sta_m} = {40'h0, 4'h4};
    if (v[5]) begin
      acc_m = v[4] ? {acc_m[39], acc_m[39:1]} : {acc_m[38:0], 1'b0};
      round_m;
    end
  endtask
  task automatic load(input logic [39:0] v);
    for (int i = 0; i < 5; i++) wr(tab[i], v[39-8*i -: 8]);
    acc_m = v;
    round_m;
  endtask
  task automatic step(input logic [15:0] a, input logic [15:0] b);
    logic [39:0] p;
    logic [39:0] n;
    p = {{24{a[15]}}, a} * {{24{b[15]}}, b};
    if (frac_m) p = p << 1;
    n = ms_m ? p : acc_m + p;
    if (!ms_m && {acc_m[39:32], n[39:32]} inside {16'h7F80, 16'h807F}) sta_m[3] = 1'b1;
    acc_m = n;
    sta_m[2:0] = {n == 40'h0, !(&n[39:31] || !(|n[39:31])), n[39]};
    round_m;
  endtask
  task automatic op(input logic [15:0] a, input logic [15:0] b, input logic twice);
    wr(ADDR_OPERAND_A_HIGH, a[15:8]);
    wr(ADDR_OPERAND_A_LOW, a[7:0]);
    wr(ADDR_OPERAND_B_HIGH, b[15:8]);
    wr(ADDR_OPERAND_B_LOW, b[7:0]);
    step(a, b);
    if (twice) begin
      wr(ADDR_OPERAND_B_LOW, b[7:0]);
      step(a, b);
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic check_all;
    logic [63:0] e;
    e = {acc_m, 4'h0, sta_m, rnd_m};
    for (int i = 0; i < 8; i++) rd(tab[i], e[63-8*i -: 8]);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    check_all;
    cfg(8'hC6);
    rd(ADDR_MAC_CONFIG, 8'h06);
    wr(ADDR_MAC_STATUS, 8'hF0);
    sta_m = 4'h0;
    rd(ADDR_MAC_STATUS, 8'h00);
    cfg(8'h0A);
    rd(ADDR_MAC_CONFIG, 8'h02);
    op(16'h4000, 16'h2000, 1'b0);
    op(16'h4000, 16'hE000, 1'b0);
    check_all;
    cfg(8'h01);
    op(16'h1234, 16'hFEDC, 1'b0);
    check_all;
    load(40'h4088442211);
    rd(ADDR_ACCUMULATOR_BYTE0, 8'h11);
    cfg(8'h20);
    cfg(8'h30);
    cfg(8'h30);
    rd(ADDR_MAC_CONFIG, 8'h10);
    check_all;
    cfg(8'h06);
    load(40'h7FFFFFFFFF);
    op(16'h4000, 16'h4000, 1'b1);
    check_all;
    repeat (5) begin
      op(16'($random(seed)), 16'($random(seed)), 1'b1);
      check_all;
    end
    wr(ADDR_MAC_STATUS, 8'h00);
    sta_m = 4'h0;
    rd(ADDR_MAC_STATUS, 8'h00);
    cfg(8'h08);
    rd(ADDR_MAC_STATUS, 8'h04);
    check_all;
    repeat (2) @(posedge clk);
    report_and_stop;
  end
endmodule
`default_nettype wire
